// File: uofl_pkg.sv
// Purpose : Shared constants for the global interrupt flag register bank.
// Assumes : 32-bit register words, byte addresses, word aligned.
// Notes   : Flag bit positions, access masks and reset values live here.
package uofl_pkg;

    localparam int          ADDR_W          = 12;

    // Register byte offsets
    localparam logic [11:0] OFS_BUS_CFG     = 12'h008;
    localparam logic [11:0] OFS_RST_CTRL    = 12'h010;
    localparam logic [11:0] OFS_IRQ_FLAGS   = 12'h014;
    localparam logic [11:0] OFS_IRQ_MASK    = 12'h018;
    localparam logic [11:0] OFS_DEV_CFG     = 12'h01C;

    // Flag bit positions
    localparam int          BIT_WAKEUP      = 31;
    localparam int          BIT_SESSION     = 30;
    localparam int          BIT_DISCONNECT  = 29;
    localparam int          BIT_ID_CHANGE   = 28;
    localparam int          BIT_PTXF_EMPTY  = 26;
    localparam int          BIT_HCH_SUM     = 25;
    localparam int          BIT_HPORT       = 24;
    localparam int          BIT_PER_INCOMPL = 21;
    localparam int          BIT_ISO_IN_INC  = 20;
    localparam int          BIT_OEP_SUM     = 19;
    localparam int          LOW_W           = 19;

    // Field positions in own control registers
    localparam int          BIT_CORE_SRST   = 0;
    localparam int          BIT_PTXF_THR    = 8;
    localparam int          EOPF_LSB        = 11;
    localparam int          EOPF_W          = 2;

    // Access classes of the flag register
    localparam logic [31:0] FLAGS_W1C_MASK  = 32'hF030_FC0A;
    localparam logic [31:0] FLAGS_RO_MASK   = 32'h070C_00F5;
    localparam logic [31:0] FLAGS_RST       = 32'h0400_0021;
    localparam logic [31:0] MASK_RST        = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

endpackage : uofl_pkg

// File: uofl_edge_det.sv
// Purpose : Detect rising and falling edges of sampled level inputs.
// Assumes : Inputs already synchronous to the clock.
// Notes   : First cycle after reset only primes the history, so no
//           spurious edge is reported for a level present at reset.
`timescale 1ns/10ps
module uofl_edge_det
    import uofl_pkg::*;
#(
    parameter int W = 2
)
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] prev_reg;
    logic         primed_reg;

    // Keep last sample; history is valid one cycle after reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev_reg   <= '0;
            primed_reg <= 1'b0;
        end
        else
        begin
            prev_reg   <= din;
            primed_reg <= 1'b1;
        end
    end

    assign rise = primed_reg ? (din & ~prev_reg) : '0;
    assign fall = primed_reg ? (~din & prev_reg) : '0;

endmodule : uofl_edge_det

// File: uofl_global_irq.sv
// Purpose : Global interrupt flag register bank of a full-speed dual-role
//           USB core, with mask, level interrupt and soft reset control.
// Assumes : All event and status inputs are synchronous to MCLK.
// Notes   : Event inputs are one-cycle pulses, pending inputs are levels.
//
// Notes on behaviour
// - Soft reset bit returns core logic to reset
// - Flag register at 0x14 resets to 0x04000021
// - Wakeup flag on resume or remote wakeup
// - Session flag on SRP or B-device VBUS valid
// - Disconnect flag set in host mode only
// - ID pin change flag on any edge
// - Periodic FIFO empty level chosen by threshold
// - Channel summary follows pending channel flags
// - Port flag follows pending port flags
// - Host: periodic incomplete at frame end
// - Device: iso OUT incomplete at periodic end
// - Device: iso IN incomplete at periodic end
// - OUT endpoint summary follows pending endpoints
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
module uofl_global_irq
    import uofl_pkg::*;
#(
    parameter int NUM_HCH = 8,
    parameter int NUM_OEP = 4
)
(
    input  wire logic               MCLK,
    input  wire logic               SRST,
    // Register port
    input  wire logic [ADDR_W-1:0]  ADDR,
    input  wire logic [31:0]        WDATA,
    input  wire logic               WR,
    input  wire logic               RD,
    output logic      [31:0]        RDATA,
    // Role and link status
    input  wire logic               HOST_MODE,
    input  wire logic               A_DEVICE,
    input  wire logic               ID_PIN,
    input  wire logic               VBUS_VALID,
    // Link events, one-cycle pulses
    input  wire logic               RESUME_DET,
    input  wire logic               REMOTE_WKUP_DET,
    input  wire logic               SRP_DET,
    input  wire logic               DEV_DISCONNECT,
    input  wire logic               FRAME_END,
    input  wire logic               EOPF_POINT,
    // Pending levels
    input  wire logic               PERIODIC_PENDING,
    input  wire logic               ISO_OUT_PENDING,
    input  wire logic               ISO_IN_PENDING,
    input  wire logic               PTXF_HALF_EMPTY,
    input  wire logic               PTXF_EMPTY,
    input  wire logic [NUM_HCH-1:0] HCH_PENDING,
    input  wire logic               PORT_PENDING,
    input  wire logic [NUM_OEP-1:0] OEP_PENDING,
    // Lower flag bits: events for write-one-clear, levels for read-only
    input  wire logic [LOW_W-1:0]   LOW_EVENTS,
    input  wire logic [LOW_W-1:0]   LOW_LEVELS,
    // Outputs
    output logic                    IRQ,
    output logic                    CORE_SRST_ACTIVE,
    output logic                    PTXF_THRESHOLD,
    output logic      [EOPF_W-1:0]  EOPF_TIME
);

    // Register state
    logic [31:0]       irq_flags_reg;
    logic [31:0]       irq_flags_next;
    logic [31:0]       irq_mask_reg;
    logic              core_srst_reg;
    logic              ptxf_thr_reg;
    logic [EOPF_W-1:0] eopf_time_reg;
    logic [31:0]       rdata_reg;
    logic              irq_reg;

    // Address decode
    logic              sel_bus_cfg;
    logic              sel_rst_ctrl;
    logic              sel_flags;
    logic              sel_mask;
    logic              sel_dev_cfg;
    logic              wr_flags;
    logic              wr_mask;
    logic              wr_rst_ctrl;
    logic              wr_bus_cfg;
    logic              wr_dev_cfg;

    // Event derivation
    logic              core_rst;
    logic [1:0]        edge_rise;
    logic [1:0]        edge_fall;
    logic              id_changed;
    logic              vbus_rise;
    logic              ev_wakeup;
    logic              ev_session;
    logic              ev_disconnect;
    logic              ev_per_incompl;
    logic              ev_iso_in_inc;
    logic              lvl_ptxf_empty;
    logic              lvl_hch_sum;
    logic              lvl_hport;
    logic              lvl_oep_sum;
    logic [31:0]       set_vec;
    logic [31:0]       ro_vec;
    logic [31:0]       clr_vec;
    logic [31:0]       bus_cfg_word;
    logic [31:0]       rst_ctrl_word;
    logic [31:0]       dev_cfg_word;
    logic [31:0]       rd_word;

    // Decoding is an if/else-if chain on the byte address
    // Exact decode, so no register shows up again at an alias address
    always_comb
    begin
        sel_bus_cfg  = 1'b0;
        sel_rst_ctrl = 1'b0;
        sel_flags    = 1'b0;
        sel_mask     = 1'b0;
        sel_dev_cfg  = 1'b0;
        if (ADDR == OFS_BUS_CFG)
            sel_bus_cfg = 1'b1;
        else if (ADDR == OFS_RST_CTRL)
            sel_rst_ctrl = 1'b1;
        else if (ADDR == OFS_IRQ_FLAGS)
            sel_flags = 1'b1;
        else if (ADDR == OFS_IRQ_MASK)
            sel_mask = 1'b1;
        else if (ADDR == OFS_DEV_CFG)
            sel_dev_cfg = 1'b1;
    end

    assign wr_flags    = WR & sel_flags;
    assign wr_mask     = WR & sel_mask;
    assign wr_rst_ctrl = WR & sel_rst_ctrl;
    assign wr_bus_cfg  = WR & sel_bus_cfg;
    assign wr_dev_cfg  = WR & sel_dev_cfg;

    // Soft reset acts like the pin reset on flags, mask and edge history,
    // but leaves the configuration registers alone,
    // so software need not rebuild them after a soft reset
    assign core_rst = SRST | core_srst_reg;

    // Edge history for ID pin and VBUS valid
    uofl_edge_det #(
        .W    (2)
    ) u_edges (
        .clk  (MCLK),
        .rst  (core_rst),
        .din  ({VBUS_VALID, ID_PIN}),
        .rise (edge_rise),
        .fall (edge_fall)
    );

    // The ID pin reports both edges; VBUS only its rising edge, so the
    // falling edge output of the VBUS lane is left unread on purpose
    assign id_changed = edge_rise[0] | edge_fall[0];
    assign vbus_rise  = edge_rise[1];

    // Sticky event sources, qualified by the current role
    assign ev_wakeup      = HOST_MODE ? REMOTE_WKUP_DET : RESUME_DET;
    assign ev_session     = A_DEVICE ? SRP_DET : vbus_rise;
    assign ev_disconnect  = HOST_MODE & DEV_DISCONNECT;
    // Bit 21 is shared: host frame end or device periodic end point
    assign ev_per_incompl = HOST_MODE ? (FRAME_END & PERIODIC_PENDING)
                                      : (EOPF_POINT & ISO_OUT_PENDING);
    assign ev_iso_in_inc  = ~HOST_MODE & EOPF_POINT & ISO_IN_PENDING;

    // Summary levels drop on their own once the source flags clear
    // They hold no state: software clears the source, never these bits
    assign lvl_ptxf_empty = HOST_MODE & (ptxf_thr_reg ? PTXF_EMPTY
                                                      : PTXF_HALF_EMPTY);
    assign lvl_hch_sum    = HOST_MODE & (|HCH_PENDING);
    assign lvl_hport      = HOST_MODE & PORT_PENDING;
    assign lvl_oep_sum    = ~HOST_MODE & (|OEP_PENDING);

    // Set vector for write-one-clear flags
    // Role qualification is done above, so this block only places bits
    always_comb
    begin
        set_vec                  = {13'h0000, LOW_EVENTS};
        set_vec[BIT_WAKEUP]      = ev_wakeup;
        set_vec[BIT_SESSION]     = ev_session;
        set_vec[BIT_DISCONNECT]  = ev_disconnect;
        set_vec[BIT_ID_CHANGE]   = id_changed;
        set_vec[BIT_PER_INCOMPL] = ev_per_incompl;
        set_vec[BIT_ISO_IN_INC]  = ev_iso_in_inc;
    end

    // Level vector for read-only flags
    always_comb
    begin
        ro_vec                 = {13'h0000, LOW_LEVELS};
        ro_vec[BIT_PTXF_EMPTY] = lvl_ptxf_empty;
        ro_vec[BIT_HCH_SUM]    = lvl_hch_sum;
        ro_vec[BIT_HPORT]      = lvl_hport;
        ro_vec[BIT_OEP_SUM]    = lvl_oep_sum;
    end

    // Only ones written to write-one-clear positions clear anything;
    // reserved bits are never stored, so stray writes there do no harm,
    // and ones aimed at read-only positions are dropped by the masks below
    assign clr_vec = wr_flags ? (WDATA & FLAGS_W1C_MASK) : WORD_ZERO;

    // Set wins over a clear in the same cycle, so no event is lost
    assign irq_flags_next = (((irq_flags_reg & ~clr_vec) | set_vec)
                             & FLAGS_W1C_MASK)
                          | (ro_vec & FLAGS_RO_MASK);

    // Flag register and mask, loaded with FLAGS_RST and MASK_RST by pin or soft reset
    // Undefined mask bits are never stored and read back as zero
    always_ff @(posedge MCLK)
    begin
        if (core_rst)
        begin
            irq_flags_reg <= FLAGS_RST;
            irq_mask_reg  <= MASK_RST;
        end
        else
        begin
            irq_flags_reg <= irq_flags_next;
            if (wr_mask)
                irq_mask_reg <= WDATA & (FLAGS_W1C_MASK | FLAGS_RO_MASK);
        end
    end

    // Soft reset bit self-clears after one cycle of reset action
    always_ff @(posedge MCLK)
    begin
        if (SRST)
            core_srst_reg <= 1'b0;
        else
            core_srst_reg <= wr_rst_ctrl & WDATA[BIT_CORE_SRST] & ~core_srst_reg;
    end

    // Configuration registers survive the soft reset
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            ptxf_thr_reg  <= 1'b0;
            eopf_time_reg <= '0;
        end
        else
        begin
            if (wr_bus_cfg)
                ptxf_thr_reg <= WDATA[BIT_PTXF_THR];
            if (wr_dev_cfg)
                eopf_time_reg <= WDATA[EOPF_LSB +: EOPF_W];
        end
    end

    // Read words, unused bits zero
    always_comb
    begin
        bus_cfg_word                         = WORD_ZERO;
        bus_cfg_word[BIT_PTXF_THR]           = ptxf_thr_reg;
        rst_ctrl_word                        = WORD_ZERO;
        rst_ctrl_word[BIT_CORE_SRST]         = core_srst_reg;
        dev_cfg_word                         = WORD_ZERO;
        dev_cfg_word[EOPF_LSB +: EOPF_W]     = eopf_time_reg;
    end

    // Unmapped addresses read as zero
    assign rd_word = sel_flags    ? irq_flags_reg :
                     sel_mask     ? irq_mask_reg  :
                     sel_rst_ctrl ? rst_ctrl_word :
                     sel_bus_cfg  ? bus_cfg_word  :
                     sel_dev_cfg  ? dev_cfg_word  : WORD_ZERO;

    // Read data stands only in the cycle after the strobe
    // Dropping to zero when idle keeps a stale word from being taken twice
    always_ff @(posedge MCLK)
    begin
        if (SRST)
            rdata_reg <= WORD_ZERO;
        else if (RD)
            rdata_reg <= rd_word;
        else
            rdata_reg <= WORD_ZERO;
    end

    // Level interrupt from any unmasked flag; one cycle behind the flags
    // The extra register keeps the pin glitch free at the cost of that cycle
    always_ff @(posedge MCLK)
    begin
        if (core_rst)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(irq_flags_reg & irq_mask_reg);
    end

    assign RDATA            = rdata_reg;
    assign IRQ              = irq_reg;
    assign CORE_SRST_ACTIVE = core_srst_reg;
    assign PTXF_THRESHOLD   = ptxf_thr_reg;
    assign EOPF_TIME        = eopf_time_reg;

endmodule : uofl_global_irq

// File: uofl_irq_checker.sv
// Purpose: Port checks for the global interrupt flag bank.
// Assumes: Levels stay steady around each read of the flags.
// Notes  : Flag reads are judged only two cycles after any reset,
//          because the mirrored bits settle first.
`timescale 1ns/10ps
module uofl_irq_checker
    import uofl_pkg::*;
#(
    parameter int NUM_HCH = 8,
    parameter int NUM_OEP = 4
)
(
    input wire logic               MCLK,
    input wire logic               SRST,
    input wire logic [ADDR_W-1:0]  ADDR,
    input wire logic [31:0]        WDATA,
    input wire logic               WR,
    input wire logic               RD,
    input wire logic [31:0]        RDATA,
    input wire logic               HOST_MODE,
    input wire logic               ID_PIN,
    input wire logic               RESUME_DET,
    input wire logic               REMOTE_WKUP_DET,
    input wire logic               DEV_DISCONNECT,
    input wire logic               PTXF_HALF_EMPTY,
    input wire logic               PTXF_EMPTY,
    input wire logic [NUM_HCH-1:0] HCH_PENDING,
    input wire logic [NUM_OEP-1:0] OEP_PENDING,
    input wire logic               IRQ,
    input wire logic               CORE_SRST_ACTIVE,
    input wire logic               PTXF_THRESHOLD
);
    logic hist1_reg;
    logic hist2_reg;
    wire  quiet = !SRST && !CORE_SRST_ACTIVE && !hist1_reg && !hist2_reg;
    wire  rdf   = RD && ADDR == OFS_IRQ_FLAGS && quiet;

    // Reset history, so reads right after a reset are skipped
    always_ff @(posedge MCLK)
    begin
        hist1_reg <= SRST | CORE_SRST_ACTIVE;
        hist2_reg <= hist1_reg;
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    property p_srst; WR && ADDR == OFS_RST_CTRL && WDATA[BIT_CORE_SRST]
        |=> CORE_SRST_ACTIVE ##1 !CORE_SRST_ACTIVE; endproperty
    a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
    property p_irq_srst; CORE_SRST_ACTIVE |=> (!IRQ)[*2]; endproperty
    a_irq_srst: assert property (p_irq_srst) else $error("irq after soft reset");
    property p_rdidle; !RD |=> RDATA == WORD_ZERO; endproperty
    a_rdidle: assert property (p_rdidle) else $error("read data not idle");
    property p_wake; (HOST_MODE ? REMOTE_WKUP_DET : RESUME_DET) && quiet ##1 rdf
        |=> RDATA[BIT_WAKEUP]; endproperty
    a_wake: assert property (p_wake) else $error("wakeup flag missing");
    property p_disc; DEV_DISCONNECT && HOST_MODE && quiet ##1 rdf
        |=> RDATA[BIT_DISCONNECT]; endproperty
    a_disc: assert property (p_disc) else $error("disconnect flag missing");
    property p_id; $changed(ID_PIN) && quiet ##1 rdf |=> RDATA[BIT_ID_CHANGE]; endproperty
    a_id: assert property (p_id) else $error("id change flag missing");
    property p_ptxf; rdf |=> RDATA[BIT_PTXF_EMPTY] ==
        $past(HOST_MODE && (PTXF_THRESHOLD ? PTXF_EMPTY : PTXF_HALF_EMPTY), 2); endproperty
    a_ptxf: assert property (p_ptxf) else $error("fifo empty flag wrong");
    property p_hch; rdf |=> RDATA[BIT_HCH_SUM] == $past(HOST_MODE && |HCH_PENDING, 2);
    endproperty
    a_hch: assert property (p_hch) else $error("channel summary wrong");
    property p_oep; rdf |=> RDATA[BIT_OEP_SUM] == $past(!HOST_MODE && |OEP_PENDING, 2);
    endproperty
    a_oep: assert property (p_oep) else $error("endpoint summary wrong");
endmodule : uofl_irq_checker

bind uofl_global_irq uofl_irq_checker #(.NUM_HCH(NUM_HCH), .NUM_OEP(NUM_OEP)) u_chk
(
    .MCLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .HOST_MODE, .ID_PIN, .RESUME_DET,
    .REMOTE_WKUP_DET, .DEV_DISCONNECT, .PTXF_HALF_EMPTY, .PTXF_EMPTY, .HCH_PENDING,
    .OEP_PENDING, .IRQ, .CORE_SRST_ACTIVE, .PTXF_THRESHOLD
);

// File: uofl_link_model.sv
// Purpose: Link side model giving bus events and pin levels.
// Assumes: The bench raises a request for one cycle only.
// Notes  : Events last one cycle, as the link logic gives them.
`timescale 1ns/10ps
module uofl_link_model
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] req,
    output logic      [5:0] pulse,
    output logic            id_pin,
    output logic            vbus
);
    // ID level toggles on request; VBUS only rises for one cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pulse  <= 6'h00;
            id_pin <= 1'h0;
            vbus   <= 1'h0;
        end
        else
        begin
            pulse  <= req[5:0];
            id_pin <= id_pin ^ req[6];
            vbus   <= req[7];
        end
    end
endmodule : uofl_link_model

// File: tb.sv
// Purpose: Self-checking bench for the global interrupt flag bank.
// Assumes: The link model raises events; the bench acts as software.
// Notes  : Fixed waits follow the one-cycle latencies of the bank.
`timescale 1ns/10ps
module tb import uofl_pkg::*;;
    typedef struct packed
    {
        logic        host;
        logic        adev;
        logic [2:0]  pend;
        logic [7:0]  req;
        logic [31:0] exp;
    } uofl_row_type;
    // Role, pending levels, event request and flags expected
    uofl_row_type rows [14] = '{
        '{1'h0, 1'h0, 3'h0, 8'h01, 32'h8000_0000}, '{1'h1, 1'h0, 3'h0, 8'h02, 32'h8000_0000},
        '{1'h1, 1'h0, 3'h0, 8'h01, 32'h0000_0000}, '{1'h1, 1'h1, 3'h0, 8'h04, 32'h4000_0000},
        '{1'h0, 1'h0, 3'h0, 8'h80, 32'h4000_0000}, '{1'h1, 1'h1, 3'h0, 8'h80, 32'h0000_0000},
        '{1'h1, 1'h0, 3'h0, 8'h08, 32'h2000_0000}, '{1'h0, 1'h0, 3'h0, 8'h08, 32'h0000_0000},
        '{1'h0, 1'h0, 3'h0, 8'h40, 32'h1000_0000}, '{1'h1, 1'h0, 3'h4, 8'h10, 32'h0020_0000},
        '{1'h0, 1'h0, 3'h3, 8'h20, 32'h0030_0000}, '{1'h0, 1'h0, 3'h1, 8'h20, 32'h0010_0000},
        '{1'h1, 1'h0, 3'h7, 8'h20, 32'h0000_0000}, '{1'h0, 1'h0, 3'h7, 8'h10, 32'h0000_0000}};
    logic        MCLK = 1'h0, SRST = 1'h1, WR = 1'h0, RD = 1'h0, HOST_MODE = 1'h1;
    logic        A_DEVICE = 1'h0, PERIODIC_PENDING = 1'h0, ISO_OUT_PENDING = 1'h0;
    logic        ISO_IN_PENDING = 1'h0, PTXF_HALF_EMPTY = 1'h1, PTXF_EMPTY = 1'h0;
    logic        PORT_PENDING = 1'h0, IRQ, CORE_SRST_ACTIVE, PTXF_THRESHOLD, ID_PIN, VBUS_VALID;
    logic [11:0] ADDR = 12'h000;
    logic [31:0] WDATA = 32'h0000_0000, RDATA, d, base;
    logic [7:0]  HCH_PENDING = 8'h00, req = 8'h00;
    logic [3:0]  OEP_PENDING = 4'h0;
    logic [18:0] LOW_EVENTS = 19'h00000, LOW_LEVELS = 19'h00021;
    logic [1:0]  EOPF_TIME;
    logic [5:0]  ev;
    int          num_errors = 0, n_compared = 0;
    uofl_row_type r;

    always #4 MCLK = ~MCLK;

    uofl_link_model u_link (.clk(MCLK), .rst(SRST), .req(req), .pulse(ev), .id_pin(ID_PIN),
        .vbus(VBUS_VALID));
    uofl_global_irq DUT
    (
        .MCLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .HOST_MODE, .A_DEVICE, .ID_PIN,
        .VBUS_VALID, .RESUME_DET(ev[0]), .REMOTE_WKUP_DET(ev[1]), .SRP_DET(ev[2]),
        .DEV_DISCONNECT(ev[3]), .FRAME_END(ev[4]), .EOPF_POINT(ev[5]), .PERIODIC_PENDING,
        .ISO_OUT_PENDING, .ISO_IN_PENDING, .PTXF_HALF_EMPTY, .PTXF_EMPTY, .HCH_PENDING,
        .PORT_PENDING, .OEP_PENDING, .LOW_EVENTS, .LOW_LEVELS, .IRQ, .CORE_SRST_ACTIVE,
        .PTXF_THRESHOLD, .EOPF_TIME
    );

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task idle(input int n);
        repeat (n) @(posedge MCLK);
    endtask : idle

    // Read data is taken one step after its edge, while it stands
    task rd(input logic [11:0] a, output logic [31:0] q);
        ADDR <= a;
        RD <= 1'h1;
        @(posedge MCLK);
        RD <= 1'h0;
        #1 q = RDATA;
        @(posedge MCLK);
    endtask : rd

    // An idle edge after each write keeps strobes from touching
    task wr(input logic [11:0] a, input logic [31:0] v);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'h1;
        @(posedge MCLK);
        WR <= 1'h0;
        @(posedge MCLK);
    endtask : wr

    task fire(input logic [7:0] v);
        req <= v;
        @(posedge MCLK);
        req <= 8'h00;
        @(posedge MCLK);
    endtask : fire

    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    initial
    begin
        idle(5);
        SRST <= 1'h0;
        rd(OFS_IRQ_FLAGS, d);
        chk("reset flags", d, FLAGS_RST);
        $display("reset test done");
        for (int i = 0; i < 14; i++)
        begin
            r = rows[i];
            HOST_MODE <= r.host;
            A_DEVICE <= r.adev;
            {PERIODIC_PENDING, ISO_OUT_PENDING, ISO_IN_PENDING} <= r.pend;
            idle(3);
            base = r.host ? FLAGS_RST : 32'h0000_0021;
            fire(r.req);
            rd(OFS_IRQ_FLAGS, d);
            chk("event flags", d, r.exp | base);
            wr(OFS_IRQ_FLAGS, WORD_ZERO);
            rd(OFS_IRQ_FLAGS, d);
            chk("after zero write", d, r.exp | base);
            wr(OFS_IRQ_FLAGS, FLAGS_W1C_MASK);
            rd(OFS_IRQ_FLAGS, d);
            chk("after clear", d, base);
            $display("row %0d done", i);
        end
        // ID change and its clear land on the same edge: the set must win
        req <= 8'h40;
        idle(1);
        req <= 8'h00;
        wr(OFS_IRQ_FLAGS, 32'h1000_0000);
        rd(OFS_IRQ_FLAGS, d);
        chk("set beats clear", d, 32'h1000_0021);
        wr(OFS_IRQ_FLAGS, FLAGS_W1C_MASK);
        $display("set priority test done");
        HOST_MODE <= 1'h1;
        HCH_PENDING <= 8'h80;
        PORT_PENDING <= 1'h1;
        idle(3);
        wr(OFS_IRQ_FLAGS, 32'h0300_0000);
        rd(OFS_IRQ_FLAGS, d);
        chk("summaries", d, FLAGS_RST | 32'h0300_0000);
        HCH_PENDING <= 8'h00;
        PORT_PENDING <= 1'h0;
        HOST_MODE <= 1'h0;
        OEP_PENDING <= 4'h8;
        idle(3);
        rd(OFS_IRQ_FLAGS, d);
        chk("endpoint summary", d, 32'h0008_0021);
        HOST_MODE <= 1'h1;
        OEP_PENDING <= 4'h0;
        wr(OFS_BUS_CFG, 32'h0000_0100);
        idle(2);
        rd(OFS_IRQ_FLAGS, d);
        chk("fifo half", d, 32'h0000_0021);
        PTXF_EMPTY <= 1'h1;
        idle(3);
        rd(OFS_IRQ_FLAGS, d);
        chk("fifo empty", d, FLAGS_RST);
        $display("summary test done");
        wr(OFS_IRQ_MASK, 32'h1000_0000);
        fire(8'h40);
        idle(2);
        chk("irq set", {31'h0, IRQ}, 32'h1);
        wr(OFS_IRQ_MASK, MASK_RST);
        idle(1);
        chk("irq masked", {31'h0, IRQ}, 32'h0);
        wr(OFS_IRQ_MASK, 32'h1000_0000);
        idle(1);
        chk("irq again", {31'h0, IRQ}, 32'h1);
        wr(OFS_RST_CTRL, 32'h0000_0001);
        idle(2);
        chk("irq soft reset", {31'h0, IRQ}, 32'h0);
        rd(OFS_IRQ_FLAGS, d);
        chk("flags soft reset", d, FLAGS_RST);
        rd(OFS_IRQ_MASK, d);
        chk("mask soft reset", d, MASK_RST);
        chk("threshold kept", {31'h0, PTXF_THRESHOLD}, 32'h1);
        wr(OFS_DEV_CFG, 32'h0000_1000);
        chk("frame time", {30'h0, EOPF_TIME}, 32'h2);
        wr(12'h0FC, 32'hFFFF_FFFF);
        rd(12'h0FC, d);
        chk("unmapped", d, WORD_ZERO);
        $display("irq test done");
        wrap_up;
    end
endmodule : tb
